// file: design/bfc_host.sv
// bfc_host: host-side controller driving a boot-block flash over its parallel pins
// assumes one request at a time on req_valid_i; pins are asynchronous to core_clk_i
`timescale 1ns/1ns
module bfc_host
  import bfc_pkg::*;
#(
  parameter longint unsigned STALL_CYC = bfc_pkg::ERASE_STALL_CYC
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   req_valid_i,
  input  wire bfc_pkg::bfc_op_e       req_op_i,
  input  wire logic [ADDR_W-1:0]      req_addr_i,
  input  wire logic [DATA_W-1:0]      req_data_i,
  output logic                        req_ready_o,
  output logic                        rsp_valid_o,
  output logic [DATA_W-1:0]           rsp_data_o,
  output logic                        rsp_stall_o,
  output logic                        chip_sel_n_o,
  output logic                        out_en_n_o,
  output logic                        write_strobe_n_o,
  output logic                        powerdown_reset_n_o,
  output logic [ADDR_W-1:0]           addr_o,
  output logic [DATA_W-1:0]           data_o,
  output logic                        data_oe_o,
  input  wire logic [DATA_W-1:0]      data_i
);
  import bfc_pkg::*;

  bfc_state_e           state_ff;
  logic [31:0]          cnt_ff;
  logic [63:0]          poll_cnt_ff;
  logic [DATA_W-1:0]    sync1_ff;
  logic [DATA_W-1:0]    sync2_ff;
  logic [DATA_W-1:0]    cmd2_ff;
  logic                 two_ff;
  logic                 poll_ff;
  logic                 cnt_zero;

  assign cnt_zero = (cnt_ff == 32'h0);

  // data pins pass two flops before use
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
    end else begin
      sync1_ff <= data_i;
      sync2_ff <= sync1_ff;
    end
  end

  // bus sequencer
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff            <= BFC_IDLE;
      cnt_ff              <= 32'h0;
      poll_cnt_ff         <= 64'h0;
      req_ready_o         <= 1'b0;
      rsp_valid_o         <= 1'b0;
      rsp_data_o          <= 8'h00;
      rsp_stall_o         <= 1'b0;
      chip_sel_n_o        <= 1'b1;
      out_en_n_o          <= 1'b1;
      write_strobe_n_o    <= 1'b1;
      powerdown_reset_n_o <= 1'b0;
      addr_o              <= '0;
      data_o              <= 8'h00;
      data_oe_o           <= 1'b0;
      cmd2_ff             <= 8'h00;
      two_ff              <= 1'b0;
      poll_ff             <= 1'b0;
    end else begin
      rsp_valid_o <= 1'b0;
      if (!cnt_zero) cnt_ff <= cnt_ff - 32'h1;
      unique case (state_ff)
        BFC_IDLE: begin
          // first request only after powerdown release recovery
          if (!powerdown_reset_n_o) begin
            powerdown_reset_n_o <= 1'b1;
            cnt_ff              <= 32'(PD_REC_CYC);
            state_ff            <= BFC_PDREC;
          end else if (req_valid_i && req_ready_o) begin
            req_ready_o <= 1'b0;
            addr_o      <= req_addr_i;
            two_ff      <= 1'b0;
            poll_ff     <= 1'b0;
            unique case (req_op_i)
              BFC_OP_CMD1: begin
                // single-write commands: FFH, 70H, 50H, B0H, D0H, 90H
                data_o   <= req_data_i;
                cnt_ff   <= 32'(SETUP_CYC);
                state_ff <= BFC_WSETUP;
              end
              BFC_OP_CMD2: begin
                // command byte then operand write at the same address
                data_o   <= req_data_i;
                cmd2_ff  <= (req_data_i == CMD_ERASE_SETUP) ? CMD_CONFIRM : 8'h00;
                two_ff   <= 1'b1;
                cnt_ff   <= 32'(SETUP_CYC);
                state_ff <= BFC_WSETUP;
              end
              BFC_OP_READ: begin
                // host releases data pins, device drives them
                data_oe_o    <= 1'b0;
                chip_sel_n_o <= 1'b0;
                out_en_n_o   <= 1'b0;
                cnt_ff       <= 32'(RD_ACC_CYC + 2);
                state_ff     <= BFC_RLOW;
              end
              BFC_OP_POLL: begin
                // status command then read until ready
                data_o      <= CMD_READ_STATUS;
                poll_ff     <= 1'b1;
                poll_cnt_ff <= 64'h0;
                rsp_stall_o <= 1'b0;
                cnt_ff      <= 32'(SETUP_CYC);
                state_ff    <= BFC_WSETUP;
              end
              BFC_OP_PDOWN: begin
                // deep powerdown deselects the chip but address pins stay driven, device resets to array read
                powerdown_reset_n_o <= 1'b0;
                chip_sel_n_o        <= 1'b1;
                cnt_ff              <= 32'(PD_LOW_CYC);
                state_ff            <= BFC_PDLOW;
              end
              default: req_ready_o <= 1'b1;
            endcase
          end else begin
            req_ready_o <= 1'b1;
          end
        end
        BFC_WSETUP: begin
          // address and data set up before strobe falls, chip selected
          chip_sel_n_o <= 1'b0;
          out_en_n_o   <= 1'b1;
          data_oe_o    <= 1'b1;
          if (cnt_zero) begin
            write_strobe_n_o <= 1'b0;
            cnt_ff           <= 32'(WE_LOW_CYC);
            state_ff         <= BFC_WLOW;
          end
        end
        BFC_WLOW: begin
          if (cnt_zero) begin
            write_strobe_n_o <= 1'b1;
            cnt_ff           <= 32'(WE_HIGH_CYC);
            state_ff         <= BFC_WHIGH;
          end
        end
        BFC_WHIGH: begin
          // hold address/data after strobe rise
          if (cnt_zero) begin
            if (two_ff) begin
              two_ff   <= 1'b0;
              data_o   <= (cmd2_ff == CMD_CONFIRM) ? CMD_CONFIRM : req_data_i;
              cnt_ff   <= 32'(SETUP_CYC);
              state_ff <= BFC_WSETUP;
            end else begin
              data_oe_o    <= 1'b0;
              chip_sel_n_o <= 1'b1;
              if (poll_ff) begin
                cnt_ff   <= 32'(WE_HIGH_CYC);
                state_ff <= BFC_POLLGAP;
              end else begin
                rsp_valid_o <= 1'b1;
                state_ff    <= BFC_IDLE;
              end
            end
          end
        end
        BFC_RLOW: begin
          if (cnt_zero) begin
            rsp_data_o <= sync2_ff;
            state_ff   <= BFC_RDONE;
          end
        end
        BFC_RDONE: begin
          // toggle selects high so the status latch refreshes
          out_en_n_o   <= 1'b1;
          chip_sel_n_o <= 1'b1;
          if (!poll_ff || rsp_data_o[READY_BIT]) begin
            rsp_valid_o <= 1'b1;
            state_ff    <= BFC_IDLE;
          end else if (poll_cnt_ff >= STALL_CYC) begin
            rsp_stall_o <= 1'b1;
            rsp_valid_o <= 1'b1;
            state_ff    <= BFC_IDLE;
          end else begin
            cnt_ff   <= 32'(WE_HIGH_CYC);
            state_ff <= BFC_POLLGAP;
          end
        end
        BFC_POLLGAP: begin
          if (cnt_zero) begin
            chip_sel_n_o <= 1'b0;
            out_en_n_o   <= 1'b0;
            cnt_ff       <= 32'(RD_ACC_CYC + 2);
            state_ff     <= BFC_RLOW;
          end
        end
        BFC_PDLOW: begin
          if (cnt_zero) begin
            rsp_valid_o <= 1'b1;
            state_ff    <= BFC_IDLE;
          end
        end
        BFC_PDREC: begin
          if (cnt_zero) state_ff <= BFC_IDLE;
        end
        default: state_ff <= BFC_IDLE;
      endcase
      // stall timeout counts whole poll duration
      if (poll_ff && state_ff != BFC_IDLE) poll_cnt_ff <= poll_cnt_ff + 64'h1;
    end
  end
endmodule

// file: design/bfc_pkg.sv
// bfc_pkg: constants for the boot flash host controller
// assumes a 125 MHz core clock and an 8-bit, 17-bit-address asynchronous flash bus
package bfc_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned ADDR_W  = 17;
  localparam int unsigned DATA_W  = 8;

  // command codes
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_PROG_SETUP   = 8'h40;
  localparam logic [7:0] CMD_PROG_SETUP2  = 8'h10;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND      = 8'hB0;
  localparam logic [7:0] CMD_SIGNATURE    = 8'h90;

  localparam logic [16:0] SIG_MAKER_ADDR = 17'h00000;
  localparam logic [16:0] SIG_PART_ADDR  = 17'h00001;
  localparam int unsigned READY_BIT      = 7;

  // bus timing, ns, and derived cycle counts (least times round up)
  localparam int unsigned T_WE_LOW_NS   = 40;
  localparam int unsigned T_WE_HIGH_NS  = 10;
  localparam int unsigned T_SETUP_NS    = 40;
  localparam int unsigned T_RD_ACC_NS   = 120;
  localparam int unsigned T_PD_REC_NS   = 480;
  localparam int unsigned T_PD_LOW_NS   = 100;
  localparam int unsigned WE_LOW_CYC  = (T_WE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WE_HIGH_CYC = (T_WE_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SETUP_CYC   = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RD_ACC_CYC  = (T_RD_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PD_REC_CYC  = (T_PD_REC_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PD_LOW_CYC  = (T_PD_LOW_NS * CLK_MHZ + 999) / 1000;

  // main block erase stall limit, ms
  localparam int unsigned T_ERASE_STALL_MS = 20900;
  localparam longint unsigned ERASE_STALL_CYC =
    longint'(T_ERASE_STALL_MS) * longint'(CLK_MHZ) * 64'd1000;

  typedef enum logic [2:0] {
    BFC_OP_CMD1   = 3'h0,
    BFC_OP_CMD2   = 3'h1,
    BFC_OP_READ   = 3'h2,
    BFC_OP_POLL   = 3'h3,
    BFC_OP_PDOWN  = 3'h4
  } bfc_op_e;

  typedef enum logic [3:0] {
    BFC_IDLE    = 4'h0,
    BFC_WSETUP  = 4'h1,
    BFC_WLOW    = 4'h2,
    BFC_WHIGH   = 4'h3,
    BFC_RLOW    = 4'h4,
    BFC_RDONE   = 4'h5,
    BFC_PDLOW   = 4'h6,
    BFC_PDREC   = 4'h7,
    BFC_POLLCMD = 4'h8,
    BFC_POLLRD  = 4'h9,
    BFC_POLLGAP = 4'hA
  } bfc_state_e;
endpackage

// file: verif/bfc_host_properties.sv
// bfc_host_properties: pin-level checks on the flash host controller
// bound to bfc_host; sees only its ports
`timescale 1ns/1ns
module bfc_host_properties
  import bfc_pkg::*;
(
  input wire logic                core_clk_i,
  input wire logic                rst_n_i,
  input wire logic                req_valid_i,
  input wire bfc_pkg::bfc_op_e    req_op_i,
  input wire logic                req_ready_o,
  input wire logic                rsp_valid_o,
  input wire logic                chip_sel_n_o,
  input wire logic                out_en_n_o,
  input wire logic                write_strobe_n_o,
  input wire logic                powerdown_reset_n_o,
  input wire logic [ADDR_W-1:0]   addr_o,
  input wire logic [DATA_W-1:0]   data_o,
  input wire logic                data_oe_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  int unsigned pd_cnt_ff;
  // cycles since the powerdown pin went high
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) pd_cnt_ff <= 0;
    else if (!powerdown_reset_n_o) pd_cnt_ff <= 0;
    else if (pd_cnt_ff < 100) pd_cnt_ff <= pd_cnt_ff + 1;
  end
  write_shape_a: assert property (!write_strobe_n_o |->
    !chip_sel_n_o && out_en_n_o && data_oe_o) else $error("bad write pins");
  read_shape_a: assert property (!out_en_n_o |->
    write_strobe_n_o && !data_oe_o && !chip_sel_n_o) else $error("bad read pins");
  pdown_quiet_a: assert property (!powerdown_reset_n_o |->
    chip_sel_n_o && write_strobe_n_o) else $error("pins active in powerdown");
  strobe_width_a: assert property ($fell(write_strobe_n_o) |->
    !write_strobe_n_o [*5]) else $error("strobe too short");
  latch_hold_a: assert property ($rose(write_strobe_n_o) |->
    $stable(addr_o) && $stable(data_o) ##1 data_oe_o) else $error("no hold");
  pd_recover_a: assert property ($fell(write_strobe_n_o) |->
    pd_cnt_ff >= 60) else $error("strobe too soon after powerdown");
  rsp_pulse_a: assert property (rsp_valid_o |=> !rsp_valid_o)
    else $error("response not one cycle");
  one_write_a: assert property (req_valid_i && req_ready_o && req_op_i == BFC_OP_CMD1
    |-> ##[10:40] rsp_valid_o) else $error("single write late");
  two_write_a: assert property (req_valid_i && req_ready_o && req_op_i == BFC_OP_CMD2
    |-> ##[20:80] rsp_valid_o) else $error("double write late");
endmodule
bind bfc_host bfc_host_properties bfc_host_properties_i (.core_clk_i, .rst_n_i,
  .req_valid_i, .req_op_i, .req_ready_o, .rsp_valid_o, .chip_sel_n_o, .out_en_n_o,
  .write_strobe_n_o, .powerdown_reset_n_o, .addr_o, .data_o, .data_oe_o);

// file: verif/bfc_flash_model.sv
// bfc_flash_model: behavioural boot flash on the host pins
// commands latch on strobe rise; clk_i times internal work and the data outputs
`timescale 1ns/1ns
module bfc_flash_model #(
  parameter logic [7:0] MAKER     = 8'h5A, // arbitrary value
  parameter logic [7:0] PART      = 8'hC3, // arbitrary value
  parameter int         PROG_CYC  = 120,
  parameter int         ERASE_CYC = 2500
) (
  input  wire logic        clk_i,
  input  wire logic        cs_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        pd_n_i,
  input  wire logic [16:0] addr_i,
  input  wire logic [7:0]  din_i,
  output logic      [7:0]  dout_o
);
  logic [7:0] mem [int];
  logic [7:0] prev = 8'h00;
  int mode = 0; // 0 array, 1 status, 2 signature
  int busy = 0;
  bit susp = 0;
  bit ers = 0;
  bit pend = 0;
  bit sig_hv = 0; // elevated signature line; this host never raises it
  initial dout_o = 8'h00;
  function automatic logic [7:0] val();
    if (mode == 1) return {busy == 0 || susp, susp, 6'h00};
    if (mode == 2 || sig_hv) return addr_i[0] ? PART : MAKER;
    return mem.exists(addr_i) ? mem[addr_i] : 8'hFF;
  endfunction
  // unselected data lines toggle rather than hold
  always @(posedge clk_i) begin
    dout_o <= (pd_n_i && !cs_n_i && !oe_n_i && we_n_i) ? val() : ~dout_o;
    if (busy > 0 && !susp) begin
      busy = busy - 1;
      if (busy == 0 && ers) mem.delete();
      if (busy == 0) ers = 0;
    end
  end
  always @(posedge we_n_i) begin
    if (pd_n_i && !cs_n_i && oe_n_i) begin
      if (busy > 0 && !ers) begin
        if (din_i == 8'h70) mode = 1;
      end else if (pend) begin
        pend = 0;
        mode = 1;
        if (prev != 8'h20) mem[addr_i] = din_i;
        if (prev != 8'h20) busy = PROG_CYC;
        if (prev == 8'h20 && din_i == 8'hD0) ers = 1;
        if (ers) busy = ERASE_CYC;
      end else begin
        case (din_i)
          8'hFF: mode = 0;
          8'h70: mode = 1;
          8'h90: mode = 2;
          8'h40, 8'h10, 8'h20: pend = 1;
          8'hB0: susp = ers;
          8'hD0: susp = 0;
          default: ;
        endcase
      end
      prev = din_i;
    end
  end
  always @(negedge pd_n_i) begin
    mode = 0;
    pend = 0; // no unlock level on this pin, boot block stays locked
  end
endmodule

// file: verif/bfc_host_tb.sv
// bfc_host_tb: self-checking bench of bfc_host against a behavioural flash
// needs the flash model and checker compiled first
`timescale 1ns/1ns
module bfc_host_tb;
  import bfc_pkg::*;
  logic core_clk_i = 0;
  logic rst_n_i = 0;
  logic req_valid_i = 0;
  bfc_op_e req_op_i = BFC_OP_CMD1;
  logic [16:0] req_addr_i = '0;
  logic [16:0] addr_o;
  logic [16:0] pa;
  logic [7:0] req_data_i = '0;
  logic [7:0] data_o, data_i, rd, pd;
  logic req_ready_o, rsp_valid_o, rsp_stall_o, chip_sel_n_o, out_en_n_o;
  logic write_strobe_n_o, powerdown_reset_n_o, data_oe_o, stall;
  logic [7:0] rsp_data_o;
  logic [7:0] cmds [2] = '{8'h40, 8'h10};
  logic [7:0] ref_mem [int];
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  always #4 core_clk_i = ~core_clk_i;
  bfc_host #(.STALL_CYC(2000)) bfc_host_i (.core_clk_i, .rst_n_i, .req_valid_i,
    .req_op_i, .req_addr_i, .req_data_i, .req_ready_o, .rsp_valid_o, .rsp_data_o,
    .rsp_stall_o, .chip_sel_n_o, .out_en_n_o, .write_strobe_n_o, .powerdown_reset_n_o,
    .addr_o, .data_o, .data_oe_o, .data_i);
  bfc_flash_model bfc_flash_model_i (.clk_i(core_clk_i), .cs_n_i(chip_sel_n_o),
    .oe_n_i(out_en_n_o), .we_n_i(write_strobe_n_o), .pd_n_i(powerdown_reset_n_o),
    .addr_i(addr_o), .din_i(data_o), .dout_o(data_i));
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  // reference array: unwritten or erased bytes read as FFH
  function automatic logic [7:0] ref_rd(input logic [16:0] a);
    return ref_mem.exists(int'(a)) ? ref_mem[int'(a)] : 8'hFF;
  endfunction
  // one request; d2 is the operand byte of a two-write command
  task automatic go(input bfc_op_e op, input logic [16:0] a, input logic [7:0] d,
                    input logic [7:0] d2);
    int n;
    n = 0;
    req_valid_i <= 1'b1;
    req_op_i <= op;
    req_addr_i <= a;
    req_data_i <= d;
    do begin @(posedge core_clk_i); n++; end while (req_ready_o !== 1'b1 && n < 200);
    req_valid_i <= 1'b0;
    req_data_i <= d2;
    do begin @(posedge core_clk_i); n++; end while (rsp_valid_o !== 1'b1 && n < 3000);
    if (rsp_valid_o !== 1'b1) begin
      n_fail++;
      $display("ERROR response expected 1 seen 0");
    end
    rd = rsp_data_o;
    stall = rsp_stall_o;
    @(posedge core_clk_i);
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done;
    end
  end
  initial begin
    void'($urandom(81));
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    go(BFC_OP_CMD1, 17'h0, 8'h90, 8'h0);
    go(BFC_OP_READ, 17'h0, 8'h0, 8'h0);
    chk("maker", 8'h5A, rd);
    go(BFC_OP_READ, 17'h1, 8'h0, 8'h0);
    chk("part", 8'hC3, rd);
    $display("test signature done");
    foreach (cmds[i]) begin
      pa = 17'($urandom);
      pd = 8'($urandom);
      go(BFC_OP_CMD2, pa, cmds[i], pd);
      ref_mem[int'(pa)] = pd;
      go(BFC_OP_POLL, pa, 8'h0, 8'h0);
      chk("ready", 8'h80, rd);
      go(BFC_OP_CMD1, 17'($urandom), 8'hFF, 8'h0);
      go(BFC_OP_READ, pa, 8'h0, 8'h0);
      chk("array", ref_rd(pa), rd);
    end
    $display("test program done");
    go(BFC_OP_CMD1, 17'($urandom), 8'h70, 8'h0);
    go(BFC_OP_READ, 17'($urandom), 8'h0, 8'h0);
    chk("status", 8'h80, rd);
    go(BFC_OP_CMD1, 17'($urandom), 8'h50, 8'h0);
    go(BFC_OP_CMD1, 17'($urandom), 8'h33, 8'h0);
    go(BFC_OP_READ, 17'($urandom), 8'h0, 8'h0);
    chk("status kept", 8'h80, rd);
    go(BFC_OP_PDOWN, 17'h0, 8'h0, 8'h0);
    go(BFC_OP_READ, pa, 8'h0, 8'h0);
    chk("after powerdown", ref_rd(pa), rd);
    $display("test status done");
    go(BFC_OP_CMD2, pa, 8'h20, 8'h0);
    ref_mem.delete();
    go(BFC_OP_CMD1, 17'($urandom), 8'hB0, 8'h0);
    go(BFC_OP_POLL, 17'h0, 8'h0, 8'h0);
    chk("suspended", 8'hC0, rd);
    go(BFC_OP_CMD1, 17'($urandom), 8'hD0, 8'h0);
    go(BFC_OP_POLL, 17'h0, 8'h0, 8'h0);
    chk("stall", 8'h01, {7'h0, stall});
    go(BFC_OP_POLL, 17'h0, 8'h0, 8'h0);
    chk("erase done", 8'h80, rd);
    go(BFC_OP_CMD1, 17'h0, 8'hFF, 8'h0);
    go(BFC_OP_READ, pa, 8'h0, 8'h0);
    chk("erased", ref_rd(pa), rd);
    $display("test erase done");
    test_done;
  end
endmodule
